/* File: common/dma_filter_cfg.svh */
`ifndef DMA_FILTER_CFG_SVH
`define DMA_FILTER_CFG_SVH

// register byte addresses, one aligned word each
`define OFS_TX_LEN_LO      12'h000
`define OFS_TX_LEN_HI      12'h004
`define OFS_RING_FIRST     12'h008
`define OFS_RING_LAST      12'h00c
`define OFS_RING_GUARD     12'h010
`define OFS_RX_WRITE       12'h014
`define OFS_LDMA_HI        12'h018
`define OFS_LDMA_LO        12'h01c
`define OFS_HX_START_HI    12'h020
`define OFS_HX_START_LO    12'h024
`define OFS_HX_COUNT_HI    12'h028
`define OFS_HX_COUNT_LO    12'h02c
`define OFS_HX_ADDR_HI     12'h030
`define OFS_HX_ADDR_LO     12'h034
`define OFS_ALIGN_TALLY    12'h038
`define OFS_CRC_TALLY      12'h03c
`define OFS_LOST_TALLY     12'h040
`define OFS_RX_CONFIG      12'h044
`define OFS_STATION_BASE   12'h080
`define OFS_HASH_BASE      12'h0a0
`define REG_STRIDE         12'h004

// receive configuration bit positions
`define CFG_ALL_ONES_BIT   0
`define CFG_ANY_PHYS_BIT   1
`define CFG_MONITOR_BIT    2
`define CFG_MULTICAST_BIT  3

`define TALLY_MAX          8'hc0
`define CRC_POLY           32'h04c11db7
`define CRC_INIT           32'hffffffff
`define HASH_LSB           26
`define DEST_BITS          6'd48
`define WORD_STEP          16'h0002
`define BYTE_STEP          16'h0001

`endif

/* File: common/dma_filter_pkg.sv */
package dma_filter_pkg;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;

    // receive-side events reported by the frame engine
    typedef struct packed {
        logic frame_start;
        logic dest_bit_valid;
        logic dest_bit;
        logic frame_end;
        logic align_error;
        logic crc_error;
        logic no_buffer;
    } rx_event_t;

    typedef enum logic [1:0] {
        X_IDLE,
        X_RUN
    } xfer_state_t;

    typedef struct packed {
        logic [15:0] tx_len;
        logic [7:0]  ring_first;
        logic [7:0]  ring_last;
        logic [7:0]  ring_guard;
        logic [7:0]  rx_write;
        logic [15:0] ldma_addr;
        logic [15:0] hx_start;
        logic [15:0] hx_count;
        logic [15:0] hx_addr;
        logic [47:0] station;
        logic [63:0] hash_bits;
        logic [7:0]  align_tally;
        logic [7:0]  crc_tally;
        logic [7:0]  lost_tally;
        logic [3:0]  rx_cfg;
        logic [31:0] crc;
        logic [5:0]  bit_cnt;
        logic [47:0] dest;
        logic [5:0]  hash_idx;
        logic        accepted;
        logic        ring_full;
        logic [31:0] prdata;
        xfer_state_t xstate;
    } state_t;

endpackage

/* File: src/dma_filter_tally_regs.sv */
`timescale 1ns/1ps
`include "dma_filter_cfg.svh"

// How it works
// - full programmed length sent, never truncated
// - ring pages are 256 bytes, low byte zero
// - next page equal guard page aborts DMA
// - write page restores pointers on error
// - local DMA address readable as two bytes
// - host transfer start loaded as two bytes
// - word steps two, byte steps one
// - host byte count high then low byte
// - current host address readable while advancing
// - destination compared against six station bytes
// - first destination bit flags group address
// - top six crc bits latched as hash
// - hash selects one filter bit for multicast
// - filter bit n in byte n/8 bit n%8
// - tallies count binary, stop at 192
// - reading a tally clears it
// - alignment tally counts recognized misaligned frames
// - crc tally counts recognized crc errors
// - lost tally counts frames without buffers
// - monitor mode lost tally counts recognized frames
// - all-ones destination accepted only when enabled
// - any physical accepted only when enabled
module dma_filter_tally_regs (
    input  wire logic                   clock,
    input  wire logic                   rst,
    input  wire dma_filter_pkg::apb_req_t apb_req,
    output dma_filter_pkg::apb_rsp_t    apb_rsp,
    input  wire dma_filter_pkg::rx_event_t rx_ev,
    input  wire logic                   ldma_tx_load,
    input  wire logic                   ldma_step,
    input  wire logic                   ldma_link,
    input  wire logic                   rx_error_restore,
    input  wire logic                   rx_commit,
    input  wire logic                   hx_go,
    input  wire logic                   hx_step,
    input  wire logic                   hx_word,
    output logic [15:0]                 tx_send_length,
    output logic [15:0]                 ldma_address,
    output logic                        ldma_abort,
    output logic [15:0]                 hx_address,
    output logic                        hx_busy,
    output logic                        hx_done,
    output logic                        frame_accept,
    output logic                        group_address_flag,
    output logic                        monitor_mode
);

    dma_filter_pkg::state_t s_q;
    dma_filter_pkg::state_t s_d;

    localparam int BYTE_W        = 8;
    localparam int STATION_BYTES = 6;
    localparam int HASH_BYTES    = 8;

    logic        wr_en;
    logic        rd_setup;
    logic        accept_now;
    logic [STATION_BYTES-1:0] st_sel;
    logic [HASH_BYTES-1:0]    hf_sel;
    logic [11:0] a;
    logic [7:0]  wb;
    logic [7:0]  next_page;
    logic        phys_match;
    logic        all_ones;
    logic        hash_hit;
    logic        recognized;
    logic [15:0] step;
    logic        crc_fb;

    assign a     = apb_req.paddr;
    assign wb    = apb_req.pwdata[7:0];
    assign wr_en = apb_req.psel & apb_req.penable & apb_req.pwrite;
    // reads are served from the setup cycle so every access needs no wait state;
    // the tally clear falls in that same cycle, so no count slips between sample and clear
    assign rd_setup = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;

    ////////////////////////////////////////////////////////////////////////////////////////

    // saturating tally step, cleared by a read; the count wins over the clear
    function automatic logic [7:0] tally(input logic [7:0] v, input logic inc, input logic clr);
        logic [7:0] base;
        base = clr ? 8'h00 : v;
        if (inc && base != `TALLY_MAX)
            tally = base + 8'h01;
        else
            tally = base;
    endfunction

    function automatic logic hit(input logic [11:0] adr, input logic [11:0] ofs);
        hit = (adr == ofs);
    endfunction

    // one decoder per byte lane of the station and filter banks
    for (genvar g = 0; g < STATION_BYTES; g++)
    begin : g_station
        assign st_sel[g] = hit(a, `OFS_STATION_BASE + `REG_STRIDE * 12'(g));
    end
    for (genvar g = 0; g < HASH_BYTES; g++)
    begin : g_hash
        assign hf_sel[g] = hit(a, `OFS_HASH_BASE + `REG_STRIDE * 12'(g));
    end

    ////////////////////////////////////////////////////////////////////////////////////////

    // page after the current local DMA page, wrapping at the ring end
    assign next_page = (s_q.ldma_addr[15:8] + 8'h01 == s_q.ring_last)
                       ? s_q.ring_first : s_q.ldma_addr[15:8] + 8'h01;

    assign phys_match = (s_q.dest == s_q.station);
    assign all_ones   = &s_q.dest;
    assign hash_hit   = s_q.hash_bits[s_q.hash_idx];
    assign step       = hx_word ? `WORD_STEP : `BYTE_STEP;
    assign crc_fb     = s_q.crc[31] ^ rx_ev.dest_bit;

    // recognition settles once all destination bits are in and holds to the next
    // frame, so a frame end is judged on it directly, not on the registered copy
    assign accept_now = (s_q.bit_cnt == `DEST_BITS) & recognized;

    always_comb
    begin
        // destination bit 0 arrives first and marks group addresses
        if (s_q.dest[0])
            recognized = all_ones ? s_q.rx_cfg[`CFG_ALL_ONES_BIT]
                       : (s_q.rx_cfg[`CFG_MULTICAST_BIT] & hash_hit);
        else
            recognized = s_q.rx_cfg[`CFG_ANY_PHYS_BIT] | phys_match;
    end

    always_comb
    begin
        s_d = s_q;

        // ---- receive address recognition ----
        if (rx_ev.frame_start)
        begin
            s_d.crc     = `CRC_INIT;
            s_d.bit_cnt = 6'd0;
            s_d.dest    = '0;
        end
        else if (rx_ev.dest_bit_valid && s_q.bit_cnt != `DEST_BITS)
        begin
            s_d.dest[s_q.bit_cnt] = rx_ev.dest_bit;
            s_d.crc     = {s_q.crc[30:0], 1'b0} ^ (crc_fb ? `CRC_POLY : 32'h0);
            s_d.bit_cnt = s_q.bit_cnt + 6'd1;
            if (s_q.bit_cnt == `DEST_BITS - 6'd1)
                s_d.hash_idx = s_d.crc[31:`HASH_LSB];
        end
        if (s_q.bit_cnt == `DEST_BITS)
            s_d.accepted = recognized;

        // ---- local DMA pointer ----
        if (ldma_tx_load)
            s_d.ldma_addr = {s_q.rx_write, 8'h00};
        else if (rx_error_restore)
            s_d.ldma_addr = {s_q.rx_write, 8'h00};
        else if (ldma_link)
        begin
            if (next_page == s_q.ring_guard)
                s_d.ring_full = 1'b1;
            else
                s_d.ldma_addr = {next_page, 8'h00};
        end
        else if (ldma_step)
            s_d.ldma_addr = s_q.ldma_addr + 16'h0001;
        if (rx_ev.frame_start)
            s_d.ring_full = 1'b0;
        if (rx_commit)
            s_d.rx_write = s_q.ldma_addr[15:8] + 8'h01 == s_q.ring_last
                           ? s_q.ring_first : s_q.ldma_addr[15:8] + 8'h01;

        // ---- host transfer engine ----
        unique case (s_q.xstate)
            dma_filter_pkg::X_IDLE:
                if (hx_go)
                begin
                    s_d.hx_addr = s_q.hx_start;
                    if (s_q.hx_count != 16'h0000)
                        s_d.xstate = dma_filter_pkg::X_RUN;
                end
            dma_filter_pkg::X_RUN:
                if (hx_step)
                begin
                    s_d.hx_addr  = s_q.hx_addr + step;
                    s_d.hx_count = (s_q.hx_count > step) ? s_q.hx_count - step : 16'h0000;
                    if (s_q.hx_count <= step)
                        s_d.xstate = dma_filter_pkg::X_IDLE;
                end
            default:
                s_d.xstate = dma_filter_pkg::X_IDLE;
        endcase

        // ---- register writes ----
        if (wr_en)
        begin
            if (hit(a, `OFS_TX_LEN_LO))   s_d.tx_len[7:0]     = wb;
            if (hit(a, `OFS_TX_LEN_HI))   s_d.tx_len[15:8]    = wb;
            if (hit(a, `OFS_RING_FIRST))  s_d.ring_first      = wb;
            if (hit(a, `OFS_RING_LAST))   s_d.ring_last       = wb;
            if (hit(a, `OFS_RING_GUARD))  s_d.ring_guard      = wb;
            if (hit(a, `OFS_RX_WRITE))    s_d.rx_write        = wb;
            if (hit(a, `OFS_HX_START_HI)) s_d.hx_start[15:8]  = wb;
            if (hit(a, `OFS_HX_START_LO)) s_d.hx_start[7:0]   = wb;
            if (hit(a, `OFS_HX_COUNT_HI)) s_d.hx_count[15:8]  = wb;
            if (hit(a, `OFS_HX_COUNT_LO)) s_d.hx_count[7:0]   = wb;
            if (hit(a, `OFS_RX_CONFIG))   s_d.rx_cfg          = wb[3:0];
            for (int i = 0; i < STATION_BYTES; i++)
            begin
                if (st_sel[i])
                    s_d.station[i*BYTE_W +: BYTE_W] = wb;
            end
            for (int i = 0; i < HASH_BYTES; i++)
            begin
                if (hf_sel[i])
                    s_d.hash_bits[i*BYTE_W +: BYTE_W] = wb;
            end
        end

        // ---- tallies: event on a completed frame, recognized except for lost frames outside monitor mode ----
        s_d.align_tally = tally(s_q.align_tally,
            rx_ev.frame_end & accept_now & rx_ev.align_error,
            rd_setup & hit(a, `OFS_ALIGN_TALLY));
        s_d.crc_tally = tally(s_q.crc_tally,
            rx_ev.frame_end & accept_now & rx_ev.crc_error,
            rd_setup & hit(a, `OFS_CRC_TALLY));
        s_d.lost_tally = tally(s_q.lost_tally,
            rx_ev.frame_end & (s_q.rx_cfg[`CFG_MONITOR_BIT]
                ? accept_now
                : (rx_ev.no_buffer | s_q.ring_full)),
            rd_setup & hit(a, `OFS_LOST_TALLY));

        // ---- read data ----
        s_d.prdata = 32'h0;
        if (rd_setup)
        begin
            unique case (1'b1)
                hit(a, `OFS_TX_LEN_LO):   s_d.prdata[7:0] = s_q.tx_len[7:0];
                hit(a, `OFS_TX_LEN_HI):   s_d.prdata[7:0] = s_q.tx_len[15:8];
                hit(a, `OFS_RING_FIRST):  s_d.prdata[7:0] = s_q.ring_first;
                hit(a, `OFS_RING_LAST):   s_d.prdata[7:0] = s_q.ring_last;
                hit(a, `OFS_RING_GUARD):  s_d.prdata[7:0] = s_q.ring_guard;
                hit(a, `OFS_RX_WRITE):    s_d.prdata[7:0] = s_q.rx_write;
                hit(a, `OFS_LDMA_HI):     s_d.prdata[7:0] = s_q.ldma_addr[15:8];
                hit(a, `OFS_LDMA_LO):     s_d.prdata[7:0] = s_q.ldma_addr[7:0];
                hit(a, `OFS_HX_START_HI): s_d.prdata[7:0] = s_q.hx_start[15:8];
                hit(a, `OFS_HX_START_LO): s_d.prdata[7:0] = s_q.hx_start[7:0];
                hit(a, `OFS_HX_COUNT_HI): s_d.prdata[7:0] = s_q.hx_count[15:8];
                hit(a, `OFS_HX_COUNT_LO): s_d.prdata[7:0] = s_q.hx_count[7:0];
                hit(a, `OFS_HX_ADDR_HI):  s_d.prdata[7:0] = s_q.hx_addr[15:8];
                hit(a, `OFS_HX_ADDR_LO):  s_d.prdata[7:0] = s_q.hx_addr[7:0];
                hit(a, `OFS_ALIGN_TALLY): s_d.prdata[7:0] = s_q.align_tally;
                hit(a, `OFS_CRC_TALLY):   s_d.prdata[7:0] = s_q.crc_tally;
                hit(a, `OFS_LOST_TALLY):  s_d.prdata[7:0] = s_q.lost_tally;
                hit(a, `OFS_RX_CONFIG):   s_d.prdata[3:0] = s_q.rx_cfg;
                default:                  s_d.prdata      = 32'h0;
            endcase
            for (int i = 0; i < STATION_BYTES; i++)
            begin
                if (st_sel[i])
                    s_d.prdata[BYTE_W-1:0] = s_q.station[i*BYTE_W +: BYTE_W];
            end
            for (int i = 0; i < HASH_BYTES; i++)
            begin
                if (hf_sel[i])
                    s_d.prdata[BYTE_W-1:0] = s_q.hash_bits[i*BYTE_W +: BYTE_W];
            end
        end
    end

    // the captured read word stands through the access phase; no wait states
    assign apb_rsp = '{pready: apb_req.psel & apb_req.penable, pslverr: 1'b0, prdata: s_q.prdata};

    assign tx_send_length     = s_q.tx_len;
    assign ldma_address       = s_q.ldma_addr;
    assign ldma_abort         = s_q.ring_full;
    assign hx_address         = s_q.hx_addr;
    assign hx_busy            = (s_q.xstate == dma_filter_pkg::X_RUN);
    assign hx_done            = hx_busy & hx_step & (s_q.hx_count <= step);
    assign frame_accept       = s_q.accepted;
    assign group_address_flag = s_q.dest[0];
    assign monitor_mode       = s_q.rx_cfg[`CFG_MONITOR_BIT];

    // all state moves together; reset clears the whole bank
    always_ff @(posedge clock)
    begin
        if (rst)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    ////////////////////////////////////////////////////////////////////////////////////////

endmodule

/* File: tb/dma_filter_chk.sv */
`timescale 1ns/1ps
`include "dma_filter_cfg.svh"
module dma_filter_chk (
    input wire logic                      clock,
    input wire logic                      rst,
    input wire dma_filter_pkg::apb_req_t  apb_req,
    input wire dma_filter_pkg::apb_rsp_t  apb_rsp,
    input wire dma_filter_pkg::rx_event_t rx_ev,
    input wire logic                      hx_go,
    input wire logic                      hx_step,
    input wire logic                      hx_word,
    input wire logic                      hx_busy,
    input wire logic [15:0]               hx_address,
    input wire logic [15:0]               tx_send_length,
    input wire logic                      group_address_flag,
    input wire logic                      monitor_mode
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    logic wr_done;
    assign wr_done = apb_req.psel && apb_req.penable && apb_req.pwrite && apb_rsp.pready;
    ////////////////////////////////////////////////////////////////////////////
    property p_word_step;
        hx_busy && hx_step && hx_word && !hx_go |=> hx_address == $past(hx_address) + `WORD_STEP;
    endproperty
    a_word_step: assert property (p_word_step)
        else $error("word step did not add two");
    property p_byte_step;
        hx_busy && hx_step && !hx_word && !hx_go |=> hx_address == $past(hx_address) + `BYTE_STEP;
    endproperty
    a_byte_step: assert property (p_byte_step)
        else $error("byte step did not add one");
    // writes are also excluded, though no register write loads the current address; only hx_go does
    property p_addr_hold;
        !hx_step && !hx_go && !wr_done |=> $stable(hx_address);
    endproperty
    a_addr_hold: assert property (p_addr_hold)
        else $error("host address moved without a step");
    property p_len_lo;
        wr_done && apb_req.paddr == `OFS_TX_LEN_LO
            |=> tx_send_length[7:0] == $past(apb_req.pwdata[7:0]);
    endproperty
    a_len_lo: assert property (p_len_lo)
        else $error("length low byte not loaded");
    property p_len_hi;
        wr_done && apb_req.paddr == `OFS_TX_LEN_HI
            |=> tx_send_length[15:8] == $past(apb_req.pwdata[7:0]);
    endproperty
    a_len_hi: assert property (p_len_hi)
        else $error("length high byte not loaded");
    property p_len_hold;
        !wr_done |=> $stable(tx_send_length);
    endproperty
    a_len_hold: assert property (p_len_hold)
        else $error("length changed without a write");
    property p_mon_cfg;
        wr_done && apb_req.paddr == `OFS_RX_CONFIG |=> monitor_mode == $past(apb_req.pwdata[2]);
    endproperty
    a_mon_cfg: assert property (p_mon_cfg)
        else $error("monitor mode does not follow config");
    property p_flag_hold;
        !rx_ev.frame_start && !rx_ev.dest_bit_valid |=> $stable(group_address_flag);
    endproperty
    a_flag_hold: assert property (p_flag_hold)
        else $error("group flag moved outside a frame");
    c_write: cover property (wr_done);
    c_step: cover property (hx_busy && hx_step);
    c_frame: cover property (rx_ev.frame_end);
endmodule

/* File: tb/host_bus_model.sv */
`timescale 1ns/1ps
module host_bus_model (
    input  wire logic                     clock,
    output dma_filter_pkg::apb_req_t      apb_req,
    input  wire dma_filter_pkg::apb_rsp_t apb_rsp
);
    initial apb_req = '0;
    // request held until pready is seen; the bench watchdog ends a hang
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r);
        @(posedge clock);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clock);
        apb_req.penable <= 1'b1;
        do @(posedge clock); while (apb_rsp.pready !== 1'b1);
        r = apb_rsp.prdata;
        apb_req <= '0;
    endtask
endmodule

/* File: tb/dma_filter_tally_regs_tb.sv */
`timescale 1ns/1ps
`include "dma_filter_cfg.svh"
module dma_filter_tally_regs_tb;
    logic                      clock;
    logic                      rst;
    dma_filter_pkg::apb_req_t  apb_req;
    dma_filter_pkg::apb_rsp_t  apb_rsp;
    dma_filter_pkg::rx_event_t rx_ev;
    logic                      hx_go;
    logic                      hx_step;
    logic                      hx_word;
    logic                      tie_low;
    logic                      ldma_ld;
    logic                      ldma_lk;
    logic [15:0]               ldma_address;
    logic                      ldma_abort;
    logic                      frame_accept;
    logic [15:0]               tx_send_length;
    logic [15:0]               hx_address;
    logic                      group_address_flag;
    logic                      monitor_mode;
    logic [31:0]               rdata;
    int                        miscompares;
    int                        cmp_count;
    host_bus_model host_bus_model_i (.clock(clock), .apb_req(apb_req), .apb_rsp(apb_rsp));
    dma_filter_tally_regs dma_filter_tally_regs_i (
        .clock(clock), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp), .rx_ev(rx_ev),
        .ldma_tx_load(ldma_ld), .ldma_step(tie_low), .ldma_link(ldma_lk),
        .rx_error_restore(tie_low), .rx_commit(tie_low), .hx_go(hx_go), .hx_step(hx_step),
        .hx_word(hx_word), .tx_send_length(tx_send_length), .ldma_address(ldma_address),
        .ldma_abort(ldma_abort), .hx_address(hx_address), .hx_busy(), .hx_done(),
        .frame_accept(frame_accept),
        .group_address_flag(group_address_flag), .monitor_mode(monitor_mode));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        host_bus_model_i.xfer(1'b1, a, {24'h0, d}, rdata);
    endtask
    task automatic rd_chk(input string what, input logic [11:0] a, input logic [7:0] exp);
        host_bus_model_i.xfer(1'b0, a, 32'h0, rdata);
        check(what, {8'h0, rdata[7:0]}, {8'h0, exp});
    endtask
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // destination bits go out lowest first, as they arrive on the wire
    task automatic send_frame(input logic [47:0] da, input logic ae, input logic ce);
        @(posedge clock) rx_ev <= '{frame_start: 1'b1, default: 1'b0};
        for (int k = 0; k < 48; k++)
            @(posedge clock) rx_ev <= '{dest_bit_valid: 1'b1, dest_bit: da[k], default: 1'b0};
        @(posedge clock) rx_ev <= '{frame_end: 1'b1, align_error: ae, crc_error: ce, default: 1'b0};
        @(posedge clock) rx_ev <= '0;
        repeat (3) @(posedge clock);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        wr(`OFS_RING_FIRST, 8'h40);
        wr(`OFS_RX_WRITE, 8'h40);
        wr(`OFS_RING_LAST, 8'h80);
        rd_chk("ring_first_page", `OFS_RING_FIRST, 8'h40);
        rd_chk("ring_last_page", `OFS_RING_LAST, 8'h80);
        rd_chk("rx_write_page", `OFS_RX_WRITE, 8'h40);
        for (int i = 0; i < 8; i++)
            wr(`OFS_HASH_BASE + 12'(i * 4), 8'h01 << i);
        for (int i = 0; i < 8; i++)
            rd_chk("hash_filter_byte", `OFS_HASH_BASE + 12'(i * 4), 8'h01 << i);
        host_bus_model_i.xfer(1'b0, 12'h0fc, 32'h0, rdata);
    endtask
    task automatic t_txlen;
        wr(`OFS_TX_LEN_LO, 8'h34);
        wr(`OFS_TX_LEN_HI, 8'hfe);
        @(posedge clock);
        check("tx_send_length", tx_send_length, 16'hfe34);
        rd_chk("tx_length_high", `OFS_TX_LEN_HI, 8'hfe);
    endtask
    task automatic t_hx;
        wr(`OFS_HX_START_LO, 8'hfe);
        wr(`OFS_HX_START_HI, 8'h12);
        wr(`OFS_HX_COUNT_LO, 8'h00);
        wr(`OFS_HX_COUNT_HI, 8'h01);
        @(posedge clock) hx_go <= 1'b1;
        @(posedge clock) hx_go <= 1'b0;
        hx_word <= 1'b1;
        @(posedge clock) hx_step <= 1'b1;
        @(posedge clock);
        @(posedge clock) hx_word <= 1'b0;
        @(posedge clock) hx_step <= 1'b0;
        repeat (2) @(posedge clock);
        check("hx_address", hx_address, 16'h1303);
        rd_chk("host_xfer_addr_high", `OFS_HX_ADDR_HI, 8'h13);
        rd_chk("host_xfer_addr_low", `OFS_HX_ADDR_LO, 8'h03);
        rd_chk("host_xfer_start_low", `OFS_HX_START_LO, 8'hfe);
        rd_chk("host_xfer_count_high", `OFS_HX_COUNT_HI, 8'h00);
        rd_chk("host_xfer_count_low", `OFS_HX_COUNT_LO, 8'hfb);
    endtask
    task automatic ldma_pulse(input logic load);
        @(posedge clock)
        begin
            ldma_ld <= load;
            ldma_lk <= ~load;
        end
        @(posedge clock)
        begin
            ldma_ld <= 1'b0;
            ldma_lk <= 1'b0;
        end
        @(posedge clock);
    endtask
    task automatic t_ring;
        wr(`OFS_RING_GUARD, 8'h42);
        wr(`OFS_RX_WRITE, 8'h7f);
        ldma_pulse(1'b1);
        ldma_pulse(1'b0);
        check("ldma_address", ldma_address, 16'h4000);
        ldma_pulse(1'b0);
        check("ldma_address", ldma_address, 16'h4100);
        ldma_pulse(1'b0);
        check("ldma_abort", {15'h0, ldma_abort}, 16'h0001);
        rd_chk("local_dma_addr_high", `OFS_LDMA_HI, 8'h41);
        rd_chk("local_dma_addr_low", `OFS_LDMA_LO, 8'h00);
    endtask
    task automatic t_frame;
        logic [47:0] st;
        st = 48'h5a4b3c2d1e10;
        for (int i = 0; i < 6; i++)
            wr(`OFS_STATION_BASE + 12'(i * 4), st[i * 8 +: 8]);
        send_frame(st, 1'b0, 1'b1);
        check("frame_accept", {15'h0, frame_accept}, 16'h0001);
        send_frame(st ^ 48'h000000000100, 1'b1, 1'b1);
        check("frame_accept", {15'h0, frame_accept}, 16'h0000);
        rd_chk("crc_error_tally", `OFS_CRC_TALLY, 8'h01);
        rd_chk("alignment_error_tally", `OFS_ALIGN_TALLY, 8'h00);
        rd_chk("crc_error_tally", `OFS_CRC_TALLY, 8'h00);
        send_frame(st | 48'h000000000001, 1'b0, 1'b0);
        check("group_address_flag", {15'h0, group_address_flag}, 16'h0001);
        check("frame_accept", {15'h0, frame_accept}, 16'h0000);
        wr(`OFS_RX_CONFIG, 8'h04);
        @(posedge clock);
        check("monitor_mode", {15'h0, monitor_mode}, 16'h0001);
        send_frame(st, 1'b0, 1'b0);
        rd_chk("lost_frame_tally", `OFS_LOST_TALLY, 8'h01);
        wr(`OFS_RX_CONFIG, 8'h03);
        send_frame({48{1'b1}}, 1'b0, 1'b0);
        check("frame_accept", {15'h0, frame_accept}, 16'h0001);
        send_frame(st ^ 48'h000000000100, 1'b0, 1'b0);
        check("frame_accept", {15'h0, frame_accept}, 16'h0001);
        wr(`OFS_RX_CONFIG, 8'h00);
    endtask
    task automatic t_lost;
        repeat (200)
        begin
            @(posedge clock) rx_ev <= '{frame_end: 1'b1, no_buffer: 1'b1, default: 1'b0};
            @(posedge clock) rx_ev <= '0;
        end
        rd_chk("lost_frame_tally", `OFS_LOST_TALLY, `TALLY_MAX);
        rd_chk("lost_frame_tally", `OFS_LOST_TALLY, 8'h00);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    initial
    begin
        rst = 1'b1;
        rx_ev = '0;
        hx_go = 1'b0;
        hx_step = 1'b0;
        hx_word = 1'b0;
        tie_low = 1'b0;
        ldma_ld = 1'b0;
        ldma_lk = 1'b0;
        miscompares = 0;
        cmp_count = 0;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        t_regs;
        t_txlen;
        t_hx;
        t_ring;
        t_frame;
        t_lost;
        report_and_stop();
    end
    initial
    begin
        #200us;
        miscompares++;
        report_and_stop();
    end
endmodule
bind dma_filter_tally_regs dma_filter_chk dma_filter_chk_i (
    .clock(clock), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp), .rx_ev(rx_ev),
    .hx_go(hx_go), .hx_step(hx_step), .hx_word(hx_word), .hx_busy(hx_busy),
    .hx_address(hx_address), .tx_send_length(tx_send_length),
    .group_address_flag(group_address_flag), .monitor_mode(monitor_mode));
